/* inc/sat_map.svh */
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH
// ----------------------------------------
// word layout and preset codes
// ----------------------------------------
`define SAT_WORD_W 6
`define SAT_CASCADE_DLY 6
`define SAT_MSB 5
`define SAT_PUP_WAIT 2'h3
`define SAT_WORD_MAX 6'h00
`define SAT_WORD_24 6'h0f
`define SAT_WORD_16 6'h1f
`define SAT_WORD_REF 6'h3f
`define SAT_PRESET_MAX 2'h0
`define SAT_PRESET_24 2'h1
`define SAT_PRESET_16 2'h2
`endif

/* inc/sat_pkg.sv */
package sat_pkg;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [5:0] sat_word_t;
    typedef struct packed {
        logic serial_mode;
        logic load_strobe;
        logic serial_clk;
        logic serial_data_in;
    } sat_serial_t;
    typedef enum logic [1:0] {
        SAT_POWERUP,
        SAT_CAPTURE,
        SAT_RUN
    } sat_state_t;
endpackage

/* logic/sat_core.sv */
`timescale 1ns/1ps
`include "sat_map.svh"
module sat_core #(
    parameter int WORD_W = `SAT_WORD_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire sat_pkg::sat_serial_t ser_in,
    input wire sat_pkg::sat_word_t atten_word_bits,
    input wire logic powerup_preset_a,
    input wire logic powerup_preset_b,
    output sat_pkg::sat_word_t atten_state,
    output logic [5:0] atten_half_db,
    output logic cascade_data_out
);
    import sat_pkg::*;

    // the decode and the ports are built for a six-bit word only
    if (WORD_W != `SAT_WORD_W) begin : g_bad_width
        $error("word width must be six");
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    sat_serial_t s1_r, s2_r, s3_r;
    sat_serial_t s1_nxt, s2_nxt, s3_nxt;
    // mode and strobe count as high only while stages two and three are both high; data is taken from stage three
    always_comb begin
        s1_nxt = ser_in;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    logic mode_ser, strobe_hi, clk_rise;
    // qualified levels and serial clock edge
    always_comb begin
        mode_ser = s2_r.serial_mode & s3_r.serial_mode;
        strobe_hi = s2_r.load_strobe & s3_r.load_strobe;
        clk_rise = s2_r.serial_clk & ~s3_r.serial_clk;
    end

    // ----------------------------------------
    // parallel word and preset synchronisers
    // ----------------------------------------
    logic [`SAT_WORD_W+1:0] p1_r, p2_r, p3_r, ph_r;
    logic [`SAT_WORD_W+1:0] p1_nxt, p2_nxt, p3_nxt, ph_nxt;
    // a new word counts only once stages two and three agree
    always_comb begin
        p1_nxt = {powerup_preset_b, powerup_preset_a, atten_word_bits};
        p2_nxt = p1_r;
        p3_nxt = p2_r;
        ph_nxt = (p2_r == p3_r) ? p3_r : ph_r;
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            p1_r <= '0;
            p2_r <= '0;
            p3_r <= '0;
            ph_r <= '0;
        end else begin
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            p3_r <= p3_nxt;
            ph_r <= ph_nxt;
        end
    end

    sat_word_t word_q;
    logic pre_a_q, pre_b_q;
    // settled word and straps, split back out of the held vector
    always_comb begin
        word_q = ph_r[`SAT_WORD_W-1:0];
        pre_a_q = ph_r[`SAT_WORD_W];
        pre_b_q = ph_r[`SAT_WORD_W+1];
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic [5:0] weigh(input sat_word_t w);
        weigh = 6'h3f & ~w;
    endfunction

    function automatic sat_word_t preset(input logic a, input logic b);
        case ({b, a})
            `SAT_PRESET_MAX: preset = `SAT_WORD_MAX;
            `SAT_PRESET_24: preset = `SAT_WORD_24;
            `SAT_PRESET_16: preset = `SAT_WORD_16;
            default: preset = `SAT_WORD_REF;
        endcase
    endfunction

    // ----------------------------------------
    // shift register and state
    // ----------------------------------------
    sat_state_t st_r, st_nxt;
    sat_word_t shreg_r, shreg_nxt;
    sat_word_t state_r, state_nxt;
    logic [5:0] hdb_r, hdb_nxt;
    logic casc_r, casc_nxt;
    logic [1:0] wait_r, wait_nxt;

    // power-up capture, shifting, latching
    always_comb begin
        st_nxt = st_r;
        shreg_nxt = shreg_r;
        state_nxt = state_r;
        wait_nxt = wait_r;
        case (st_r)
            SAT_POWERUP: begin
                // let synchronisers fill before sampling straps
                wait_nxt = wait_r + 2'h1;
                if (wait_r == `SAT_PUP_WAIT) begin
                    st_nxt = SAT_CAPTURE;
                end
            end
            SAT_CAPTURE: begin
                if (strobe_hi) begin
                    state_nxt = word_q;
                end else begin
                    state_nxt = preset(pre_a_q, pre_b_q);
                end
                st_nxt = SAT_RUN;
            end
            SAT_RUN: begin
                if (mode_ser) begin
                    if (clk_rise && !strobe_hi) begin
                        shreg_nxt = {shreg_r[`SAT_MSB-1:0], s3_r.serial_data_in};
                    end
                end else begin
                    shreg_nxt = word_q;
                end
                if (strobe_hi) begin
                    state_nxt = mode_ser ? shreg_r : word_q;
                end
            end
            default: st_nxt = SAT_POWERUP;
        endcase
        hdb_nxt = weigh(state_nxt);
        casc_nxt = shreg_nxt[`SAT_MSB];
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= SAT_POWERUP;
            shreg_r <= `SAT_WORD_REF;
            state_r <= `SAT_WORD_REF;
            hdb_r <= 6'h00;
            casc_r <= 1'b1;
            wait_r <= 2'h0;
        end else begin
            st_r <= st_nxt;
            shreg_r <= shreg_nxt;
            state_r <= state_nxt;
            hdb_r <= hdb_nxt;
            casc_r <= casc_nxt;
            wait_r <= wait_nxt;
        end
    end

    assign atten_state = state_r;
    assign atten_half_db = hdb_r;
    assign cascade_data_out = casc_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_hold_low_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_RUN && !strobe_hi) |=> $stable(state_r))
        else $error("state changed while strobe low");
    a_weight_match: assert property (@(posedge ref_clk) disable iff (!rstn)
        hdb_r == (6'h3f & ~state_r))
        else $error("weight does not match state");
    a_cascade_tap: assert property (@(posedge ref_clk) disable iff (!rstn)
        cascade_data_out == shreg_r[`SAT_MSB])
        else $error("cascade not last stage");
    a_mask_clock: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_RUN && strobe_hi && mode_ser) |=> $stable(shreg_r))
        else $error("shift while strobe high");
    a_serial_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_RUN && strobe_hi && mode_ser) |=> state_r == $past(shreg_r))
        else $error("serial word not loaded");
    a_parallel_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_RUN && !mode_ser) |=> shreg_r == $past(word_q))
        else $error("parallel word not captured");
    a_shift_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_RUN && mode_ser && clk_rise && !strobe_hi)
        |=> shreg_r == {$past(shreg_r[4:0]), $past(s3_r.serial_data_in)})
        else $error("shift step wrong");
    a_preset_pick: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_CAPTURE && !strobe_hi && !pre_a_q && !pre_b_q)
        |=> state_r == `SAT_WORD_MAX)
        else $error("preset max not taken");
    a_preset_mid: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_CAPTURE && !strobe_hi && pre_a_q && !pre_b_q)
        |=> state_r == `SAT_WORD_24)
        else $error("preset 24 dB not taken");
    a_powerup_word: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_r == SAT_CAPTURE && strobe_hi) |=> state_r == $past(word_q))
        else $error("power-up word not taken");

    // power-up walks wait, capture, run in that order
    sequence s_wait_done;
        st_r == SAT_POWERUP && wait_r == `SAT_PUP_WAIT;
    endsequence
    sequence s_capture_run;
        st_r == SAT_CAPTURE ##1 st_r == SAT_RUN;
    endsequence
    a_powerup_steps: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_wait_done |=> s_capture_run)
        else $error("power-up sequence broken");
endmodule

/* bench/sat_ctl_model.sv */
`timescale 1ns/1ps
module sat_ctl_model (
    input wire logic ref_clk,
    output sat_pkg::sat_serial_t ser
);
    import sat_pkg::*;
    // ----
    // external controller
    // ----
    initial ser = '0;
    // one 40 ns phase of the 80 ns serial clock
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask
    // mode select and strobe levels
    task automatic pins(input logic m, input logic s);
        ser.serial_mode = m;
        ser.load_strobe = s;
    endtask
    // shift a word msb first; the clock stands low outside frames
    task automatic send(input logic [5:0] w);
        for (int i = 5; i >= 0; i--) begin
            ser.serial_data_in = w[i];
            half();
            ser.serial_clk = 1'b1;
            half();
            ser.serial_clk = 1'b0;
        end
        ser.serial_data_in = ~w[0]; // released line shows the inverse
    endtask
    // load pulse after the last clock
    task automatic pulse();
        half();
        ser.load_strobe = 1'b1;
        half();
        ser.load_strobe = 1'b0;
    endtask
endmodule

/* bench/step_attenuator_control_logic_bench.sv */
`timescale 1ns/1ps
module step_attenuator_control_logic_bench;
    import sat_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sat_serial_t ser_in;
    sat_word_t word = 6'h3f;
    logic pa = 1'b0;
    logic pb = 1'b0;
    sat_word_t atten_state;
    logic [5:0] half_db;
    logic casc;
    sat_word_t exp_q[$];
    sat_word_t pre[4] = '{6'h00, 6'h0f, 6'h1f, 6'h3f};
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    event look;
    // ----
    // clock, partner and design
    // ----
    initial forever #5 ref_clk = ~ref_clk;
    sat_ctl_model i_ctl (.ref_clk(ref_clk), .ser(ser_in));
    sat_core i_dut (.ref_clk(ref_clk), .rstn(rstn), .ser_in(ser_in),
        .atten_word_bits(word), .powerup_preset_a(pa), .powerup_preset_b(pb),
        .atten_state(atten_state), .atten_half_db(half_db), .cascade_data_out(casc));
    // ----
    // checking
    // ----
    task automatic check(input string what, input logic [5:0] e, input logic [5:0] s);
        samples_checked++;
        if (e !== s) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // queue a note, let the result settle, then wake the watcher
    task automatic note(input sat_word_t e);
        exp_q.push_back(e);
        repeat (12) @(negedge ref_clk);
        -> look;
    endtask
    task automatic power_up();
        rstn = 1'b0;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
    endtask
    // watcher takes the oldest note
    always @(look) begin : watch
        sat_word_t e;
        e = exp_q.pop_front();
        check("state", e, atten_state);
        check("half_db", ~e, half_db);
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        sat_word_t w;
        void'($urandom(93));
        for (int i = 0; i < 4; i++) begin
            {pb, pa} = i[1:0];
            power_up();
            note(pre[i]);
        end
        word = sat_word_t'($urandom);
        i_ctl.pins(1'b0, 1'b1);
        power_up();
        note(word);
        i_ctl.pins(1'b0, 1'b0);
        w = word;
        word = ~word;
        note(w);
        i_ctl.send(sat_word_t'($urandom));
        note(w);
        i_ctl.pulse();
        note(word);
        i_ctl.pins(1'b1, 1'b0);
        repeat (3) begin
            w = sat_word_t'($urandom);
            i_ctl.send(w);
            repeat (8) @(negedge ref_clk);
            check("cascade", {5'h00, w[5]}, {5'h00, casc});
            i_ctl.pulse();
            note(w);
        end
        i_ctl.pins(1'b1, 1'b1);
        i_ctl.send(~w);
        i_ctl.pins(1'b1, 1'b0);
        note(w);
        tally_and_finish();
    end
endmodule
